// ---- core/dsmon_top.sv ----
// Timeslot capture monitor: one transmit and one receive slot at once.
// Assumes framer bit strobes synchronous to clk_in, Avalon-MM word index.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
module dsmon_top (
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   // Avalon-MM slave
   input  wire logic [7:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   // Transmit timeslot path
   input  wire logic        tx_bit_stb_in,
   input  wire logic        tx_bit_in,
   input  wire logic [4:0]  tx_slot_in,
   input  wire logic [2:0]  tx_bit_idx_in,
   // Receive timeslot path
   input  wire logic        rx_bit_stb_in,
   input  wire logic        rx_bit_in,
   input  wire logic [4:0]  rx_slot_in,
   input  wire logic [2:0]  rx_bit_idx_in
);

   // ----------------------------------------------------------------
   // Local sizes and types
   // ----------------------------------------------------------------
   // Capture engine slots in the per-direction arrays
   localparam int DIR_TX = 0;
   localparam int DIR_RX = 1;
   localparam int DIRS   = 2;

   // Bus phase; a single bit, so every step is a Gray step
   typedef enum logic {
      DSMON_HOLD   = 1'b0,
      DSMON_ANSWER = 1'b1
   } dsmon_bus_t;

   // ----------------------------------------------------------------
   // Registers and bus signals
   // ----------------------------------------------------------------
   logic [7:0] common_control_five_ff;
   logic [7:0] common_control_six_ff;
   logic [7:0] tx_timeslot_capture;
   logic [7:0] rx_timeslot_capture;
   dsmon_bus_t bus_state_ff;
   dsmon_bus_t nxt_bus_state;
   logic       req;
   logic       take;
   logic       wr_five;
   logic       wr_six;
   logic [7:0] nxt_five;
   logic [7:0] nxt_six;
   logic [7:0] nxt_rdata;

   // ----------------------------------------------------------------
   // Per-direction framer, select and capture signals, indexed by direction
   // ----------------------------------------------------------------
   logic [4:0] sel_dir  [DIRS];
   logic       stb_dir  [DIRS];
   logic       bit_dir  [DIRS];
   logic [4:0] slot_dir [DIRS];
   logic [2:0] idx_dir  [DIRS];
   logic [7:0] cap_dir  [DIRS];

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   // Write strobe for one register index, completing edge only
   function automatic logic wr_hit(input logic       taken,
                                   input logic       write,
                                   input logic [7:0] idx,
                                   input logic [7:0] reg_idx);
      return taken && write && (idx == reg_idx);
   endfunction

   // Channel select field of a control register
   function automatic logic [4:0] sel_field(input logic [7:0] ctrl);
      return ctrl[dsmon_pkg::SEL_MSB:0];
   endfunction

   // Read mux over the register map, unmapped indices read zero
   function automatic logic [7:0] read_mux(input logic [7:0] idx,
                                           input logic [7:0] c5,
                                           input logic [7:0] c6,
                                           input logic [7:0] txc,
                                           input logic [7:0] rxc);
      logic [7:0] val;
      val = 8'h00;
      unique case (idx)
         dsmon_pkg::REG_CTRL_FIVE: val = c5;
         dsmon_pkg::REG_TX_CAP:    val = txc;
         dsmon_pkg::REG_CTRL_SIX:  val = c6;
         dsmon_pkg::REG_RX_CAP:    val = rxc;
         default:                  val = 8'h00;
      endcase
      return val;
   endfunction

   // ----------------------------------------------------------------
   // Bus handshake: one wait cycle, then the access completes
   // ----------------------------------------------------------------
   // Request present, and request completing on this edge
   assign req  = avs_read_in || avs_write_in;
   assign take = req && (bus_state_ff == DSMON_ANSWER);

   // Hold answers a request next edge; answer always falls back
   always_comb begin
      nxt_bus_state = DSMON_HOLD;
      unique case (bus_state_ff)
         DSMON_HOLD: begin
            if (req) begin
               nxt_bus_state = DSMON_ANSWER;
            end
         end
         DSMON_ANSWER: begin
            nxt_bus_state = DSMON_HOLD;
         end
      endcase
   end

   // Handshake phase register
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         bus_state_ff <= DSMON_HOLD;
      end else begin
         bus_state_ff <= nxt_bus_state;
      end
   end

   // Waitrequest low only in the answer phase, straight from a flop
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         avs_waitrequest_out <= 1'b1;
      end else begin
         avs_waitrequest_out <= (nxt_bus_state != DSMON_ANSWER);
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Register map lookup for the index on the bus
   assign nxt_rdata = read_mux(avs_address_in,
                               common_control_five_ff,
                               common_control_six_ff,
                               tx_timeslot_capture,
                               rx_timeslot_capture);

   // Loaded in the hold phase, so it stands at the answer edge
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         avs_readdata_out <= 32'h0000_0000;
      end else if (avs_read_in && bus_state_ff == DSMON_HOLD) begin
         avs_readdata_out <= {24'h00_0000, nxt_rdata};
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   // Write strobes, one per writable index
   assign wr_five = wr_hit(take, avs_write_in, avs_address_in,
                           dsmon_pkg::REG_CTRL_FIVE);
   assign wr_six  = wr_hit(take, avs_write_in, avs_address_in,
                           dsmon_pkg::REG_CTRL_SIX);

   // Stored values: full byte, and receive byte without its gap
   assign nxt_five = avs_writedata_in[7:0];
   assign nxt_six  = avs_writedata_in[7:0] & dsmon_pkg::CTRL_SIX_MASK;

   // Transmit control register, full byte kept
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         common_control_five_ff <= dsmon_pkg::CTRL_FIVE_RST;
      end else if (wr_five) begin
         common_control_five_ff <= nxt_five;
      end
   end

   // Receive control register, unassigned bits read zero
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         common_control_six_ff <= dsmon_pkg::CTRL_SIX_RST;
      end else if (wr_six) begin
         common_control_six_ff <= nxt_six;
      end
   end

   // ----------------------------------------------------------------
   // Capture engines, one per direction, running together
   // ----------------------------------------------------------------
   // Transmit inputs and select field
   assign sel_dir[DIR_TX]  = sel_field(common_control_five_ff);
   assign stb_dir[DIR_TX]  = tx_bit_stb_in;
   assign bit_dir[DIR_TX]  = tx_bit_in;
   assign slot_dir[DIR_TX] = tx_slot_in;
   assign idx_dir[DIR_TX]  = tx_bit_idx_in;

   // Receive inputs and select field
   assign sel_dir[DIR_RX]  = sel_field(common_control_six_ff);
   assign stb_dir[DIR_RX]  = rx_bit_stb_in;
   assign bit_dir[DIR_RX]  = rx_bit_in;
   assign slot_dir[DIR_RX] = rx_slot_in;
   assign idx_dir[DIR_RX]  = rx_bit_idx_in;

   // One shift-and-post engine per direction
   generate
      for (genvar d = 0; d < DIRS; d++) begin : g_dir
         dsmon_capture u_cap (
            .clk_in     (clk_in),
            .rstn_in    (rstn_in),
            .sel_in     (sel_dir[d]),
            .bit_stb_in (stb_dir[d]),
            .bit_in     (bit_dir[d]),
            .slot_in    (slot_dir[d]),
            .bit_idx_in (idx_dir[d]),
            .cap_out    (cap_dir[d])
         );
      end
   endgenerate

   // Capture bytes under their register names
   assign tx_timeslot_capture = cap_dir[DIR_TX];
   assign rx_timeslot_capture = cap_dir[DIR_RX];

endmodule

// ---- core/dsmon_pkg.sv ----
// Constants for the timeslot capture monitor.
// Assumes word-indexed register access from a 32-bit Avalon-MM master.
package dsmon_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL_FIVE = 8'h19;
   localparam logic [7:0] REG_TX_CAP    = 8'h1A;
   localparam logic [7:0] REG_CTRL_SIX  = 8'h1E;
   localparam logic [7:0] REG_RX_CAP    = 8'h1F;

   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam int         SEL_MSB        = 4;
   localparam int         SEL_W          = 5;
   localparam int         CTRL_SIX_TOP   = 7;
   localparam logic [7:0] CTRL_FIVE_RST  = 8'h00;
   localparam logic [7:0] CTRL_SIX_MASK  = 8'h9F;
   localparam logic [7:0] CTRL_SIX_RST   = 8'h00;
   localparam logic [7:0] CAP_RST        = 8'h00;

   // ----------------------------------------------------------------
   // Timeslot geometry
   // ----------------------------------------------------------------
   localparam int         SLOT_BITS      = 8;
   localparam logic [2:0] LAST_BIT_IDX   = 3'h7;

endpackage

// ---- core/dsmon_capture.sv ----
// One direction's timeslot capture: shifts the selected slot's bits.
// Assumes bit strobes with slot number and bit index synchronous to clk.
`timescale 1ns/1ps
module dsmon_capture (
   input  wire logic       clk_in,
   input  wire logic       rstn_in,
   input  wire logic [4:0] sel_in,
   input  wire logic       bit_stb_in,
   input  wire logic       bit_in,
   input  wire logic [4:0] slot_in,
   input  wire logic [2:0] bit_idx_in,
   output logic      [7:0] cap_out
);

   // ----------------------------------------------------------------
   // Shift and load
   // ----------------------------------------------------------------
   logic [6:0] shift_ff;
   logic       hit;

   // Bit belongs to the selected slot
   assign hit = bit_stb_in && (slot_in == sel_in);

   // First bit lands in bit 7, last in bit 0
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         shift_ff <= 7'h00;
      end else if (hit) begin
         shift_ff <= {shift_ff[5:0], bit_in};
      end
   end

   // Whole byte posted once per frame on the slot's last bit
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         cap_out <= dsmon_pkg::CAP_RST;
      end else if (hit && bit_idx_in == dsmon_pkg::LAST_BIT_IDX) begin
         cap_out <= {shift_ff, bit_in};
      end
   end

endmodule

// ---- sim/dsmon_props.sv ----
// Bus checks for the timeslot monitor top.
// Assumes only the top's ports; bound below the module.
`timescale 1ns/1ps
module dsmon_props (
   input wire logic        clk_in,
   input wire logic        rstn_in,
   input wire logic [7:0]  avs_address_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic        avs_waitrequest_out
);
   logic       done;
   logic       rdn;
   logic [7:0] c5_ff;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   // Access completes, read completes
   assign done = !avs_waitrequest_out;
   assign rdn  = avs_read_in && done;
   // Shadow of the transmit select register
   always_ff @(posedge clk_in) begin
      if (!rstn_in)
         c5_ff <= 8'h00;
      else if (avs_write_in && done && avs_address_in == 8'h19)
         c5_ff <= avs_writedata_in[7:0];
   end
   AST_ACK_NEXT: assert property (
      (avs_read_in || avs_write_in) && !done |=> done)
      else $error("request not answered on the next edge");
   AST_ACK_ONE: assert property (
      done |=> !done)
      else $error("waitrequest low for more than one cycle");
   AST_ACK_CAUSE: assert property (
      done |-> $past(avs_read_in || avs_write_in))
      else $error("answer without a request");
   AST_HIGH_ZERO: assert property (
      rdn |-> avs_readdata_out[31:8] == 24'h0)
      else $error("upper read data not zero");
   AST_SIX_GAP: assert property (
      rdn && avs_address_in == 8'h1E |-> avs_readdata_out[6:5] == 2'h0)
      else $error("unassigned select bits read back set");
   AST_UNMAP: assert property (
      rdn && !(avs_address_in inside {8'h19, 8'h1A, 8'h1E, 8'h1F})
      |-> avs_readdata_out == 32'h0)
      else $error("unmapped read not zero");
   AST_CTRL5: assert property (
      rdn && avs_address_in == 8'h19 |-> avs_readdata_out[7:0] == c5_ff)
      else $error("transmit select readback wrong");
endmodule
bind dsmon_top dsmon_props u_props (.*);

// ---- sim/dsmon_framer.sv ----
// Framer timeslot stream: slots 1..24, eight bits each, first bit first.
// Assumes go_in pulses once; slot byte is slot times 1D hex xor key.
`timescale 1ns/1ps
module dsmon_framer (
   input  wire logic       clk_in,
   input  wire logic       go_in,
   input  wire logic [7:0] key_in,
   output logic            stb_out,
   output logic            bit_out,
   output logic      [4:0] slot_out,
   output logic      [2:0] idx_out
);
   logic [7:0] c_ff = 8'h00;
   logic       tgl_ff = 1'b0;
   logic [7:0] k;
   logic [7:0] b;
   // Frame bit counter, idle at zero; idle line toggles each cycle
   always @(posedge clk_in) begin
      tgl_ff <= ~tgl_ff;
      if (go_in || c_ff != 8'h00)
         c_ff <= (c_ff == 8'hC0) ? 8'h00 : c_ff + 8'h01;
   end
   // Slot, bit position and data of the current bit
   assign k        = c_ff - 8'h01;
   assign stb_out  = c_ff != 8'h00;
   assign slot_out = k[7:3] + 5'h01;
   assign idx_out  = k[2:0];
   assign b        = 8'({3'h0, slot_out} * 8'h1D) ^ key_in;
   assign bit_out  = stb_out ? b[3'h7 - idx_out] : tgl_ff;
endmodule

// ---- sim/dsmon_tb_top.sv ----
// Self-checking bench for the timeslot capture monitor.
// Assumes dsmon_top, dsmon_framer and the bound checker.
`timescale 1ns/1ps
module dsmon_tb_top;
   logic        clk_in = 1'b0, rstn_in = 1'b0, rd = 1'b0, wr = 1'b0;
   logic        go = 1'b0, wreq, ts, tb, rs, rb;
   logic [7:0]  adr = 8'h00, ktx = 8'h00, krx = 8'h00, er, q[$];
   logic [31:0] wdat = 32'h0, rdat;
   logic [4:0]  tsl, rsl, t5, r5;
   logic [2:0]  ti, ri;
   logic [15:0] lf = 16'h0DB1;
   logic [7:0]  ra[5] = '{8'h19, 8'h1A, 8'h1E, 8'h1F, 8'h20};
   int          fails = 0, samples_checked = 0;
   initial forever #50 clk_in = ~clk_in;
   dsmon_framer u_tx (.clk_in(clk_in), .go_in(go), .key_in(ktx),
      .stb_out(ts), .bit_out(tb), .slot_out(tsl), .idx_out(ti));
   dsmon_framer u_rx (.clk_in(clk_in), .go_in(go), .key_in(krx),
      .stb_out(rs), .bit_out(rb), .slot_out(rsl), .idx_out(ri));
   dsmon_top dut (.clk_in(clk_in), .rstn_in(rstn_in),
      .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in(wdat), .avs_readdata_out(rdat),
      .avs_waitrequest_out(wreq), .tx_bit_stb_in(ts), .tx_bit_in(tb),
      .tx_slot_in(tsl), .tx_bit_idx_in(ti), .rx_bit_stb_in(rs),
      .rx_bit_in(rb), .rx_slot_in(rsl), .rx_bit_idx_in(ri));
   function automatic logic [15:0] nx(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [7:0] bv(input logic [4:0] s, input logic [7:0] k);
      return 8'({3'h0, s} * 8'h1D) ^ k;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED readdata exp %h seen %h", exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // One bus access, held until waitrequest is seen low
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      adr <= a;
      wdat <= {24'h0, d};
      rd <= !w;
      wr <= w;
      do begin
         @(posedge clk_in);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 50) begin
         fails++;
         report_and_stop();
      end
      @(posedge clk_in);
   endtask
   task automatic rdq(input logic [7:0] a, input logic [7:0] e);
      q.push_back(e);
      acc(1'b0, a, 8'h00);
   endtask
   // One full frame on both directions at once
   task automatic frame;
      go <= 1'b1;
      @(posedge clk_in);
      go <= 1'b0;
      repeat (200) @(posedge clk_in);
   endtask
   // Oldest expected read value against the completed read
   always @(posedge clk_in)
      if (rd && wreq === 1'b0) chk(rdat, {24'h0, q.pop_front()});
   initial begin
      repeat (4) @(posedge clk_in);
      rstn_in <= 1'b1;
      @(posedge clk_in);
      foreach (ra[i]) rdq(ra[i], 8'h00);
      for (int i = 0; i < 3; i++) begin
         lf = nx(nx(lf));
         t5 = 5'(lf[7:0] % 8'h18) + 5'h01;
         r5 = 5'(lf[15:8] % 8'h18) + 5'h01;
         ktx <= lf[15:8];
         krx <= lf[7:0];
         acc(1'b1, 8'h19, {lf[7:5], t5});
         rdq(8'h19, {lf[7:5], t5});
         acc(1'b1, 8'h1E, {lf[15], 2'h0, r5});
         rdq(8'h1E, {lf[15], 2'h0, r5});
         frame();
         er = bv(r5, krx);
         rdq(8'h1A, bv(t5, ktx));
         rdq(8'h1F, er);
      end
      acc(1'b1, 8'h1E, 8'h9F);
      acc(1'b1, 8'h1A, 8'h5A);
      rdq(8'h1E, 8'h9F);
      ktx <= ~ktx;
      frame();
      rdq(8'h1A, bv(t5, ktx));
      rdq(8'h1F, er);
      report_and_stop();
   end
endmodule
